// [hw/quad_dac_consts.vh]
// Purpose: shared constants of the four-channel converter holding-register block
// Assumes: 16-bit multiplexed address/data bus, 12-bit converter codes
// Notes:   definitions only
`ifndef QUAD_DAC_CONSTS_VH
`define QUAD_DAC_CONSTS_VH

// bus and code widths
`define BUS_W          16
`define CODE_W         12
`define NUM_CH         4
`define CH_SEL_W       2
`define LOW_BYTE_MSB   7
`define HIGH_BYTE_LSB  8

// field positions inside the captured address word
`define ADDR_BYTE_BIT  0
`define ADDR_SEL_LO    1
`define ADDR_SEL_HI    2
`define ADDR_BASE_LO   3
`define ADDR_BASE_HI   11
`define BASE_W         9

// width of the parallel output taken from the last channel
`define DOUT_W         4

// reset values
`define HOLD_RESET     12'h000
`define BUS_RESET      16'h0000
`define RANGE_W        2

`endif

// [hw/quad_dac_holding_registers.v]
// Purpose: bus-side logic of a four-channel analog output module
// Assumes: one 20 MHz clock; bus pins and jumpers arrive asynchronously
// Notes:   the analog converters sit outside; this block only stores and serves codes

`include "quad_dac_consts.vh"

`default_nettype none

// three-stage pin synchroniser: the stable value follows only when stages two and
// three agree, so a glitch caught by the first stage never reaches the logic
module pin_sync #(
  parameter W = 1
) (
  input  wire         clock,
  input  wire         rst,
  input  wire [W-1:0] pin,
  output reg  [W-1:0] stable_q
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;

  // first stage is read by the second stage only
  always @(posedge clock) begin
    if (rst) begin
      s1_q     <= {W{1'b0}};
      s2_q     <= {W{1'b0}};
      s3_q     <= {W{1'b0}};
      stable_q <= {W{1'b0}};
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        stable_q <= s3_q;
      end
    end
  end
endmodule // pin_sync

// Functional notes
// - four channels, each with its own register, addressed without touching others.
// - each register is written as a whole word or as one byte, and read as a whole word.
// - each register feeds a 12-bit code to its converter channel.
// - low four bits of the fourth register also drive four parallel output lines.
// - single storage level; a write reaches the converter at once.
// - polarity and range come only from jumper inputs, never from a register.
// - address bits 1 and 2 of the captured address pick the register.
// - cycle is ours only with io page select and bits 3-11 matching switches.
// - no control or status register; outputs follow the last written value.
// - read cycles drive the selected register onto the bus; writes latch bus data.
module quad_dac_holding_registers (
  input  wire                  clock,
  input  wire                  rst,
  input  wire [`BUS_W-1:0]     muxed_address_data_lines_in,
  output reg  [`BUS_W-1:0]     muxed_address_data_lines_out,
  output reg                   muxed_address_data_lines_oe,
  input  wire                  addr_strobe,
  input  wire                  read_strobe,
  input  wire                  write_strobe,
  input  wire                  byte_write,
  input  wire                  io_page_select,
  input  wire [`BASE_W-1:0]    base_switch,
  output reg                   reply,
  input  wire                  bipolar_jumper,
  input  wire [`RANGE_W-1:0]   range_jumper,
  output wire [`CODE_W-1:0]    dac_code_0,
  output wire [`CODE_W-1:0]    dac_code_1,
  output wire [`CODE_W-1:0]    dac_code_2,
  output wire [`CODE_W-1:0]    dac_code_3,
  output wire [`DOUT_W-1:0]    parallel_out,
  output wire                  dac_bipolar,
  output wire [`RANGE_W-1:0]   dac_range
);

  // one-hot bus cycle states
  localparam [4:0] ST_IDLE   = 5'h01;
  localparam [4:0] ST_ADDR   = 5'h02;
  localparam [4:0] ST_READ   = 5'h04;
  localparam [4:0] ST_WRITE  = 5'h08;
  localparam [4:0] ST_IGNORE = 5'h10;

  wire [4:0]            ctl_s;
  wire [`BUS_W-1:0]     lines_s;
  wire [`BASE_W-1:0]    base_s;
  wire [`RANGE_W:0]     jumper_s;
  wire                  as_s;
  wire                  rd_s;
  wire                  wr_s;
  wire                  bw_s;
  wire                  page_s;

  reg  [4:0]            state_q;
  reg  [4:0]            state_d;
  reg  [`CH_SEL_W-1:0]  sel_q;
  reg  [`CH_SEL_W-1:0]  sel_d;
  reg                   high_byte_q;
  reg                   high_byte_d;
  reg  [`CODE_W-1:0]    hold_q [0:`NUM_CH-1];
  reg  [`CODE_W-1:0]    write_val;
  reg                   write_en;
  reg  [`BUS_W-1:0]     out_d;
  reg                   oe_d;
  reg                   reply_d;
  wire                  addr_hit;
  integer               i;

  // bus controls share one synchroniser so they stay aligned to each other
  pin_sync #(.W(5)) u_ctl_sync (
    .clock    (clock),
    .rst      (rst),
    .pin      ({io_page_select, byte_write, write_strobe, read_strobe, addr_strobe}),
    .stable_q (ctl_s)
  );

  // data lines are sampled by the same depth, so they settle in the same cycle as strobes set with them
  pin_sync #(.W(`BUS_W)) u_line_sync (
    .clock    (clock),
    .rst      (rst),
    .pin      (muxed_address_data_lines_in),
    .stable_q (lines_s)
  );

  // switch pack and jumpers are static, but still come from off the clock domain
  pin_sync #(.W(`BASE_W)) u_base_sync (
    .clock    (clock),
    .rst      (rst),
    .pin      (base_switch),
    .stable_q (base_s)
  );

  pin_sync #(.W(`RANGE_W + 1)) u_jumper_sync (
    .clock    (clock),
    .rst      (rst),
    .pin      ({bipolar_jumper, range_jumper}),
    .stable_q (jumper_s)
  );

  assign as_s   = ctl_s[0];
  assign rd_s   = ctl_s[1];
  assign wr_s   = ctl_s[2];
  assign bw_s   = ctl_s[3];
  assign page_s = ctl_s[4];

  // polarity and range pass straight through; no bus access reaches them
  assign dac_bipolar = jumper_s[`RANGE_W];
  assign dac_range   = jumper_s[`RANGE_W-1:0];

  // device select: io page plus address bits 3-11 equal to the switch pattern
  assign addr_hit = page_s &&
                    (lines_s[`ADDR_BASE_HI:`ADDR_BASE_LO] == base_s);

  // converter codes come straight from the single holding level
  assign dac_code_0  = hold_q[0];
  assign dac_code_1  = hold_q[1];
  assign dac_code_2  = hold_q[2];
  assign dac_code_3  = hold_q[3];
  assign parallel_out = hold_q[`NUM_CH-1][`DOUT_W-1:0];

  // merge the incoming bus data into the selected register; only one lane on a
  // byte write, and bits above the code width are dropped
  always @* begin
    write_val = hold_q[sel_q];
    if (bw_s && high_byte_q) begin
      write_val[`CODE_W-1:`HIGH_BYTE_LSB] =
        lines_s[`CODE_W-1:`HIGH_BYTE_LSB];
    end else if (bw_s) begin
      write_val[`LOW_BYTE_MSB:0] = lines_s[`LOW_BYTE_MSB:0];
    end else begin
      write_val = lines_s[`CODE_W-1:0];
    end
  end

  // bus cycle sequencer; a read may be followed by a write in the same address
  // cycle, so after each data phase we fall back to the addressed state
  always @* begin
    state_d     = state_q;
    sel_d       = sel_q;
    high_byte_d = high_byte_q;
    out_d       = muxed_address_data_lines_out;
    oe_d        = muxed_address_data_lines_oe;
    reply_d     = reply;
    write_en    = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (as_s && addr_hit) begin
          sel_d       = lines_s[`ADDR_SEL_HI:`ADDR_SEL_LO];
          high_byte_d = lines_s[`ADDR_BYTE_BIT];
          state_d     = ST_ADDR;
        end else if (as_s) begin
          state_d = ST_IGNORE;   // someone else's cycle: stay off the bus
        end
      end
      ST_ADDR: begin
        if (!as_s) begin
          state_d = ST_IDLE;
        end else if (rd_s) begin
          out_d   = {{(`BUS_W-`CODE_W){1'b0}}, hold_q[sel_q]};
          oe_d    = 1'b1;
          reply_d = 1'b1;
          state_d = ST_READ;
        end else if (wr_s) begin
          write_en = 1'b1;
          reply_d  = 1'b1;
          state_d  = ST_WRITE;
        end
      end
      ST_READ: begin
        if (!rd_s || !as_s) begin
          out_d   = `BUS_RESET;
          oe_d    = 1'b0;
          reply_d = 1'b0;
          state_d = as_s ? ST_ADDR : ST_IDLE;
        end
      end
      ST_WRITE: begin
        if (!wr_s || !as_s) begin
          reply_d = 1'b0;
          state_d = as_s ? ST_ADDR : ST_IDLE;
        end
      end
      ST_IGNORE: begin
        if (!as_s) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        out_d   = `BUS_RESET;
        oe_d    = 1'b0;
        reply_d = 1'b0;
        state_d = ST_IDLE;
      end
    endcase
  end

  // sequencer and bus drivers
  always @(posedge clock) begin
    if (rst) begin
      state_q                      <= ST_IDLE;
      sel_q                        <= {`CH_SEL_W{1'b0}};
      high_byte_q                  <= 1'b0;
      muxed_address_data_lines_out <= `BUS_RESET;
      muxed_address_data_lines_oe  <= 1'b0;
      reply                        <= 1'b0;
    end else begin
      state_q                      <= state_d;
      sel_q                        <= sel_d;
      high_byte_q                  <= high_byte_d;
      muxed_address_data_lines_out <= out_d;
      muxed_address_data_lines_oe  <= oe_d;
      reply                        <= reply_d;
    end
  end

  // holding registers: only the selected one changes on a write
  always @(posedge clock) begin
    if (rst) begin
      for (i = 0; i < `NUM_CH; i = i + 1) begin
        hold_q[i] <= `HOLD_RESET;
      end
    end else if (write_en) begin
      hold_q[sel_q] <= write_val;
    end
  end

endmodule // quad_dac_holding_registers

`default_nettype wire

// [testbench/host_bus_model.sv]
// Purpose: processor model running one strobed bus cycle per call
// Assumes: levels change just after a rising edge and stand several cycles
// Notes:   released lines show the inverse of the last value
`default_nettype none
module host_bus_model (
  input wire logic        clock,
  input wire logic [15:0] lines,
  input wire logic        reply,
  output var logic [15:0] host_lines,
  output var logic        addr_strobe,
  output var logic        read_strobe,
  output var logic        write_strobe,
  output var logic        byte_write,
  output var logic        io_page_select
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {host_lines, addr_strobe, read_strobe, write_strobe, byte_write, io_page_select} = '0;
  end
  // got stays low when the block stays silent, as on an address miss
  task automatic cycle(input logic [15:0] addr, input logic wr, input logic bw,
                       input logic sel, input logic [15:0] wd,
                       output logic [15:0] rd, output logic got);
    int n;
    @(posedge clock);
    host_lines <= addr;
    io_page_select <= sel;
    addr_strobe <= 1'b1;
    repeat (6) @(posedge clock);
    host_lines <= wr ? wd : ~addr; // raw codes, no format change
    byte_write <= bw;
    write_strobe <= wr;
    read_strobe <= !wr;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (reply !== 1'b1 && n < 10);
    rd = lines;
    got = reply;
    write_strobe <= 1'b0;
    read_strobe <= 1'b0;
    repeat (7) @(posedge clock);
    {addr_strobe, io_page_select, byte_write} <= 3'h0;
    host_lines <= ~host_lines;
    repeat (6) @(posedge clock);
  endtask
endmodule // host_bus_model
`default_nettype wire

// [testbench/quad_dac_holding_registers_test.sv]
// Purpose: self-checking bench for the four-channel holding registers
// Assumes: host model drives the bus; jumpers static between checks
// Notes:   expected codes are kept in ex[]
`default_nettype none
module quad_dac_holding_registers_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0, rst = 1'b1, bip = 1'b1, got;
  logic [1:0] rng = 2'h2;
  logic [8:0] base = 9'h089;
  logic [15:0] hl, out, rd;
  logic oe, reply, as_s, rd_s, wr_s, bw, sel;
  logic [11:0] ex[4] = '{default: 12'h000}; // codes clear at reset
  wire [11:0] c0, c1, c2, c3;
  wire [3:0] dout;
  wire dbip;
  wire [1:0] drng;
  wire [15:0] lines = oe ? out : hl;
  int bad_count = 0, checks_done = 0, cycles = 0;
  quad_dac_holding_registers u_quad_dac_holding_registers (.clock, .rst,
    .muxed_address_data_lines_in(lines), .muxed_address_data_lines_out(out),
    .muxed_address_data_lines_oe(oe), .addr_strobe(as_s), .read_strobe(rd_s),
    .write_strobe(wr_s), .byte_write(bw), .io_page_select(sel), .base_switch(base),
    .reply, .bipolar_jumper(bip), .range_jumper(rng), .dac_code_0(c0),
    .dac_code_1(c1), .dac_code_2(c2), .dac_code_3(c3), .parallel_out(dout),
    .dac_bipolar(dbip), .dac_range(drng));
  host_bus_model u_host_bus_model (.clock, .lines, .reply, .host_lines(hl),
    .addr_strobe(as_s), .read_strobe(rd_s), .write_strobe(wr_s), .byte_write(bw),
    .io_page_select(sel));
  task automatic finish_test();
    if (bad_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // one host cycle to channel ch; b picks the byte lane bit of the address
  task automatic acc(input logic [1:0] ch, input logic b, input logic wr, input logic [15:0] d);
    u_host_bus_model.cycle({4'h1, base, ch, b}, wr, b & wr, 1'b1, d, rd, got);
  endtask
  task automatic word_rw();
    for (int i = 0; i < 4; i++) begin
      ex[i] = 12'h5a3 + 12'h111 * i[11:0];
      acc(i[1:0], 1'b0, 1'b1, {4'hf, ex[i]});
      chk({got, c3, c2, c1, c0}, {1'b1, ex[3], ex[2], ex[1], ex[0]});
    end
    for (int i = 0; i < 4; i++) begin
      acc(i[1:0], 1'b0, 1'b0, 16'h0000);
      chk({got, rd}, {1'b1, 4'h0, ex[i]});
    end
    chk(dout, ex[3][3:0]);
  endtask
  task automatic byte_rw();
    u_host_bus_model.cycle({4'h1, base, 2'h1, 1'b0}, 1'b1, 1'b1, 1'b1, 16'hffa5,
                           rd, got);
    chk(c1, {ex[1][11:8], 8'ha5});
    acc(2'h1, 1'b1, 1'b1, 16'hfcff);
    chk(c1, 12'hca5);
    acc(2'h1, 1'b1, 1'b0, 16'h0000);
    chk(rd, 16'h0ca5);
    ex[1] = 12'hca5;
  endtask
  task automatic miss();
    u_host_bus_model.cycle({4'h1, base, 2'h2, 1'b0}, 1'b1, 1'b0, 1'b0, 16'h0123,
                           rd, got);
    chk({got, c2}, {1'b0, ex[2]});
    u_host_bus_model.cycle({4'h1, base ^ 9'h100, 2'h2, 1'b0}, 1'b1, 1'b0, 1'b1,
                           16'h0123, rd, got);
    chk({got, c2}, {1'b0, ex[2]});
  endtask
  task automatic jumpers();
    chk({dbip, drng}, 3'h6);
    @(posedge clock);
    bip <= 1'b0;
    rng <= 2'h1;
    repeat (8) @(posedge clock);
    chk({dbip, drng, c3}, {3'h1, ex[3]});
  endtask
  initial begin
    forever #25 clock = ~clock;
  end
  // hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      finish_test();
    end
  end
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    repeat (8) @(posedge clock);
    chk({oe, reply, c3, c2, c1, c0}, 50'h0);
    word_rw();
    byte_rw();
    miss();
    jumpers();
    finish_test();
  end
endmodule // quad_dac_holding_registers_test
bind quad_dac_holding_registers quad_dac_props u_quad_dac_props (.clock, .rst, .read_strobe,
  .write_strobe, .io_page_select, .bipolar_jumper, .muxed_address_data_lines_out,
  .muxed_address_data_lines_oe, .reply, .dac_code_0, .dac_code_3, .parallel_out, .dac_bipolar);
`default_nettype wire

// [testbench/quad_dac_props.sv]
// Purpose: bus reply and code-output checks at the block's ports
// Assumes: sync delay of four edges as handed over
// Notes:   bound from the testbench top
`default_nettype none
`include "quad_dac_consts.vh"
module quad_dac_props (
  input wire logic               clock,
  input wire logic               rst,
  input wire logic               read_strobe,
  input wire logic               write_strobe,
  input wire logic               io_page_select,
  input wire logic               bipolar_jumper,
  input wire logic [`BUS_W-1:0]  muxed_address_data_lines_out,
  input wire logic               muxed_address_data_lines_oe,
  input wire logic               reply,
  input wire logic [`CODE_W-1:0] dac_code_0,
  input wire logic [`CODE_W-1:0] dac_code_3,
  input wire logic [`DOUT_W-1:0] parallel_out,
  input wire logic               dac_bipolar
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // the bus is only driven while a reply stands
  oe_reply_a: assert property (
    muxed_address_data_lines_oe |-> reply)
    else $error("oe without reply");
  out_idle_a: assert property (
    !muxed_address_data_lines_oe |-> muxed_address_data_lines_out == 16'h0000)
    else $error("data out while idle");
  upper_zero_a: assert property (
    muxed_address_data_lines_out[15:12] == 4'h0)
    else $error("upper bits nonzero");
  dout_follow_a: assert property (
    parallel_out == dac_code_3[3:0])
    else $error("parallel out differs");
  reply_sel_a: assert property (
    $rose(reply) |-> $past(io_page_select, 3))
    else $error("reply without select");
  read_oe_a: assert property (
    $rose(reply) && $past(read_strobe, 3) |-> muxed_address_data_lines_oe)
    else $error("read not driven");
  write_oe_a: assert property (
    $rose(reply) && $past(write_strobe, 3) |-> !muxed_address_data_lines_oe)
    else $error("write drove bus");
  // only an answered strobe has a reply to hold; an ignored cycle never raises one
  reply_drop_a: assert property (
    ($fell(read_strobe) || $fell(write_strobe)) && reply |-> reply [*3] ##[1:4] !reply)
    else $error("reply timing");
  // code 0 moves only as a result of a write
  code_hold_a: assert property (
    $changed(dac_code_0) |-> $past(write_strobe, 3))
    else $error("code moved alone");
  jumper_a: assert property (
    $changed(bipolar_jumper) |-> ##[3:6] dac_bipolar == bipolar_jumper)
    else $error("jumper not seen");
  read_c: cover property ($rose(reply) && $past(read_strobe, 3));
  write_c: cover property ($rose(reply) && $past(write_strobe, 3));
  code_c: cover property ($changed(dac_code_3));
endmodule // quad_dac_props
`default_nettype wire
